// ### logic/pwm_ctrl_pkg.sv
package pwm_ctrl_pkg;

  // Structure of the counter array seen by this block
  localparam int CHANNELS = 3;
  localparam int CNT_W    = 16;
  localparam int BYTE_W   = 8;

  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h01;
  localparam logic [7:0] ADDR_EVT_MASK   = 8'h02;
  localparam logic [7:0] ADDR_CMP_BASE   = 8'h10;
  localparam logic [7:0] ADDR_CMP_LAST   = 8'h15;

  // Field positions of pwm_global_control
  localparam int BIT_BANK_SEL   = 7;
  localparam int BIT_IRQ_EN     = 6;
  localparam int BIT_CYCLE_OVERFLOW_FLAG       = 5;
  localparam int BIT_UNUSED     = 4;
  localparam int BIT_RELOAD_EN  = 3;
  localparam int CYCLE_LENGTH_SELECT_LSB      = 0;
  localparam int CYCLE_LENGTH_SELECT_W        = 3;

  // Field positions of the event status and mask registers
  localparam int EVT_W      = 2;
  localparam int EVT_CYCLE_OVERFLOW_FLAG   = 0;
  localparam int EVT_RELOAD = 1;

  // Reset values
  localparam logic [7:0]       CTRL_RESET   = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RESET    = 2'h0;
  localparam logic [CNT_W-1:0] SLOT_RESET   = 16'h0000;

  // Cycle length of code zero; code k gives this plus k bits
  localparam logic [3:0]       BASE_CYCLE_BITS = 4'h8;
  localparam logic [CNT_W-1:0] FULL_COUNT      = 16'hffff;

endpackage

// ### logic/channel_reload_slot.sv
`timescale 1ns/1ps

module channel_reload_slot
  import pwm_ctrl_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              write_lo,
  input  wire logic              write_hi,
  input  wire logic              bank_select,
  input  wire logic [BYTE_W-1:0] write_byte,
  input  wire logic              reload,
  output logic      [W-1:0]      compare_value,
  output logic      [W-1:0]      reload_value
);

  logic [W-1:0] compare_reg;
  logic [W-1:0] compare_next;
  logic [W-1:0] reload_reg;
  logic [W-1:0] reload_next;

  // Bank select steers byte writes; a software write to the compare
  // bank beats a reload in the same cycle so the written value sticks
  always_comb begin
    compare_next = compare_reg;
    reload_next  = reload_reg;
    if (reload) begin
      compare_next = reload_reg;
    end
    if (bank_select) begin
      if (write_lo) begin
        reload_next[BYTE_W-1:0] = write_byte;
      end
      if (write_hi) begin
        reload_next[W-1:BYTE_W] = write_byte;
      end
    end else begin
      if (write_lo) begin
        compare_next[BYTE_W-1:0] = write_byte;
      end
      if (write_hi) begin
        compare_next[W-1:BYTE_W] = write_byte;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      compare_reg <= SLOT_RESET;
      reload_reg  <= SLOT_RESET;
    end else begin
      compare_reg <= compare_next;
      reload_reg  <= reload_next;
    end
  end

  assign compare_value = compare_reg;
  assign reload_value  = reload_reg;

endmodule

// ### logic/pwm_cycle_length_reload_ctrl.sv
// Functional notes
// - Cycle overflow flag sets when the selected counter bit, 7 to 14, overflows.
// - The cycle length select field picks which counter bit drives the flag.
// - Flag set by hardware or software write; only software clears it.
// - Control bit 4 reads zero and ignores writes.
// - Reload enable set: counter overflow copies shadow values into compares.
// - Reload enable applies to every channel in 16-bit mode at once.
// - Reload enable clear (default): no automatic reload at all.
// - Three-bit field sets 8 to 15 bit period for non-16-bit channels.
// - Channels in 16-bit mode ignore the field and use full period.
// - Code k gives 8 plus k bits: 000 is 8, 111 is 15.
// - Irq enable set: flag set raises the interrupt; clear: only unmasked status events interrupt.
// - Bank select steers compare addresses to compare or shadow registers.
`timescale 1ns/1ps

module pwm_cycle_length_reload_ctrl
  import pwm_ctrl_pkg::*;
(
  input  wire logic                           sys_clk,
  input  wire logic                           sys_rst,
  input  wire logic [7:0]                     reg_addr,
  input  wire logic [BYTE_W-1:0]              reg_wdata,
  input  wire logic                           reg_write,
  input  wire logic                           reg_read,
  output logic      [BYTE_W-1:0]              reg_rdata,
  input  wire logic [CNT_W-1:0]               main_counter,
  input  wire logic                           counter_step,
  input  wire logic [CHANNELS-1:0]            chan_pwm16,
  output logic      [CHANNELS-1:0][CNT_W-1:0] compare_value,
  output logic      [CHANNELS-1:0]            cycle_wrap,
  output logic      [CNT_W-1:0]               cycle_mask,
  output logic                                irq
);

  logic [7:0]          ctrl_reg;
  logic [7:0]          ctrl_next;
  logic [EVT_W-1:0]    status_reg;
  logic [EVT_W-1:0]    status_next;
  logic [EVT_W-1:0]    mask_reg;
  logic [EVT_W-1:0]    mask_next;
  logic [BYTE_W-1:0]   rdata_reg;
  logic [BYTE_W-1:0]   rdata_next;
  logic [CHANNELS-1:0] wrap_reg;
  logic [CHANNELS-1:0] wrap_next;
  logic [CNT_W-1:0]    cmask_reg;
  logic [CNT_W-1:0]    cmask_next;

  logic [CYCLE_LENGTH_SELECT_W-1:0]  cycle_length_select;
  logic [3:0]          cycle_bits;
  logic [CNT_W-1:0]    low_mask;
  logic                cycle_overflow_flag_event;
  logic                full_overflow;
  logic                reload_en;
  logic                bank_sel;
  logic                irq_en;
  logic                cycle_overflow_flag;
  logic [CHANNELS-1:0] chan_reload;
  logic                ctrl_wr;
  logic                cmp_hit;
  logic [7:0]          cmp_off;
  logic [1:0]          cmp_chan;
  logic                cmp_high;
  logic [CHANNELS-1:0] cmp_wr_lo;
  logic [CHANNELS-1:0] cmp_wr_hi;
  logic [CHANNELS-1:0][CNT_W-1:0] reload_value;

  // Field views of the control register
  assign cycle_length_select     = ctrl_reg[CYCLE_LENGTH_SELECT_LSB +: CYCLE_LENGTH_SELECT_W];
  assign reload_en = ctrl_reg[BIT_RELOAD_EN];
  assign bank_sel  = ctrl_reg[BIT_BANK_SEL];
  assign irq_en    = ctrl_reg[BIT_IRQ_EN];
  assign cycle_overflow_flag      = ctrl_reg[BIT_CYCLE_OVERFLOW_FLAG];
  assign ctrl_wr   = reg_write && (reg_addr == ADDR_CONTROL);

  // Code k selects 8 plus k bits of cycle length
  assign cycle_bits = BASE_CYCLE_BITS + {1'b0, cycle_length_select};

  // Mask of the low N counter bits for the selected cycle length
  always_comb begin
    low_mask = '0;
    for (int i = 0; i < CNT_W; i++) begin
      low_mask[i] = (i < int'(cycle_bits));
    end
  end

  // Counter steps past all ones in the low N bits: carry out of bit N-1.
  // The counter itself lives outside; step marks its increment edge.
  assign cycle_overflow_flag_event = counter_step &&
                      ((main_counter & low_mask) == low_mask);
  assign full_overflow = counter_step && (main_counter == FULL_COUNT);

  // One global enable gates the reload of every 16-bit channel
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      chan_reload[c] = reload_en && full_overflow && chan_pwm16[c];
    end
  end

  // Compare window decode: two bytes per channel, low byte first
  assign cmp_hit  = (reg_addr >= ADDR_CMP_BASE) &&
                    (reg_addr <= ADDR_CMP_LAST);
  assign cmp_off  = reg_addr - ADDR_CMP_BASE;
  assign cmp_chan = cmp_off[2:1];
  assign cmp_high = cmp_off[0];

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      cmp_wr_lo[c] = reg_write && cmp_hit && !cmp_high &&
                     (cmp_chan == 2'(c));
      cmp_wr_hi[c] = reg_write && cmp_hit && cmp_high &&
                     (cmp_chan == 2'(c));
    end
  end

  // Control register: bit 4 is never stored; the flag set wins over a
  // software clear in the same cycle so no overflow is ever lost
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next = reg_wdata;
      ctrl_next[BIT_UNUSED] = 1'b0;
    end
    if (cycle_overflow_flag_event) begin
      ctrl_next[BIT_CYCLE_OVERFLOW_FLAG] = 1'b1;
    end
  end

  // Event status is write one to clear; new events win over the clear
  always_comb begin
    status_next = status_reg;
    mask_next   = mask_reg;
    if (reg_write && (reg_addr == ADDR_EVT_STATUS)) begin
      status_next = status_reg & ~reg_wdata[EVT_W-1:0];
    end
    if (reg_write && (reg_addr == ADDR_EVT_MASK)) begin
      mask_next = reg_wdata[EVT_W-1:0];
    end
    if (cycle_overflow_flag_event) begin
      status_next[EVT_CYCLE_OVERFLOW_FLAG] = 1'b1;
    end
    if (|chan_reload) begin
      status_next[EVT_RELOAD] = 1'b1;
    end
  end

  // Read data stand in the cycle after the strobe only; unmapped reads 0
  always_comb begin
    rdata_next = '0;
    if (reg_read) begin
      if (reg_addr == ADDR_CONTROL) begin
        rdata_next = ctrl_reg;
        rdata_next[BIT_UNUSED] = 1'b0;
      end else if (reg_addr == ADDR_EVT_STATUS) begin
        rdata_next = {{(BYTE_W-EVT_W){1'b0}}, status_reg};
      end else if (reg_addr == ADDR_EVT_MASK) begin
        rdata_next = {{(BYTE_W-EVT_W){1'b0}}, mask_reg};
      end else if (cmp_hit) begin
        for (int c = 0; c < CHANNELS; c++) begin
          if (cmp_chan == 2'(c)) begin
            if (bank_sel) begin
              rdata_next = cmp_high ? reload_value[c][CNT_W-1:BYTE_W]
                                    : reload_value[c][BYTE_W-1:0];
            end else begin
              rdata_next = cmp_high ? compare_value[c][CNT_W-1:BYTE_W]
                                    : compare_value[c][BYTE_W-1:0];
            end
          end
        end
      end
    end
  end

  // Per-channel period end: 16-bit channels ignore the length field
  always_comb begin
    cmask_next = low_mask;
    for (int c = 0; c < CHANNELS; c++) begin
      wrap_next[c] = chan_pwm16[c] ? full_overflow : cycle_overflow_flag_event;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_reg   <= CTRL_RESET;
      status_reg <= EVT_RESET;
      mask_reg   <= EVT_RESET;
      rdata_reg  <= '0;
      wrap_reg   <= '0;
      cmask_reg  <= '0;
    end else begin
      ctrl_reg   <= ctrl_next;
      status_reg <= status_next;
      mask_reg   <= mask_next;
      rdata_reg  <= rdata_next;
      wrap_reg   <= wrap_next;
      cmask_reg  <= cmask_next;
    end
  end

  // Compare and shadow pair of each channel
  for (genvar g = 0; g < CHANNELS; g++) begin : g_slot
    channel_reload_slot #(
      .W (CNT_W)
    ) u_slot (
      .sys_clk       (sys_clk),
      .sys_rst       (sys_rst),
      .write_lo      (cmp_wr_lo[g]),
      .write_hi      (cmp_wr_hi[g]),
      .bank_select   (bank_sel),
      .write_byte    (reg_wdata),
      .reload        (chan_reload[g]),
      .compare_value (compare_value[g]),
      .reload_value  (reload_value[g])
    );
  end

  assign reg_rdata  = rdata_reg;
  assign cycle_wrap = wrap_reg;
  assign cycle_mask = cmask_reg;

  // Level interrupt from registered state only, so it never glitches
  assign irq = (cycle_overflow_flag && irq_en) || |(status_reg & mask_reg);

  // Flag and status: hardware sets, only software clears
  chk_flag_sets: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cycle_overflow_flag_event |=> cycle_overflow_flag)
    else $error("cycle overflow flag not set after event");

  chk_flag_bit_pick: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (counter_step && !ctrl_wr &&
     main_counter[int'(cycle_bits)-1 -: 1] == 1'b0) |=> !$rose(cycle_overflow_flag))
    else $error("flag rose while selected bit was not carrying");

  chk_flag_sticky: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $fell(cycle_overflow_flag) |-> $past(ctrl_wr) && !$past(reg_wdata[BIT_CYCLE_OVERFLOW_FLAG]))
    else $error("cycle overflow flag cleared without software write");

  chk_set_beats_clear: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (cycle_overflow_flag_event && ctrl_wr) |=> cycle_overflow_flag)
    else $error("overflow lost to a software clear");

  chk_soft_set: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (ctrl_wr && reg_wdata[BIT_CYCLE_OVERFLOW_FLAG]) |=> cycle_overflow_flag)
    else $error("software write of one did not set the flag");

  chk_status_cycle_overflow_flag: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cycle_overflow_flag_event |=> status_reg[EVT_CYCLE_OVERFLOW_FLAG])
    else $error("overflow event not recorded in status");

  chk_status_clear: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (reg_write && reg_addr == ADDR_EVT_STATUS && reg_wdata[EVT_CYCLE_OVERFLOW_FLAG] &&
     !cycle_overflow_flag_event) |=> !status_reg[EVT_CYCLE_OVERFLOW_FLAG])
    else $error("status bit not cleared by writing one");

  chk_unused_zero: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (reg_read && reg_addr == ADDR_CONTROL) |=> !reg_rdata[BIT_UNUSED])
    else $error("unused control bit read as one");

  // Reload of the 16-bit channels
  chk_reload_copy: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (chan_reload[0] && !cmp_wr_lo[0] && !cmp_wr_hi[0])
    |=> compare_value[0] == $past(reload_value[0]))
    else $error("reload did not copy shadow into compare");

  chk_reload_status: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (|chan_reload) |=> status_reg[EVT_RELOAD])
    else $error("reload not recorded in status");

  chk_reload_all: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (reload_en && full_overflow) |-> chan_reload == chan_pwm16)
    else $error("reload not applied to every 16-bit channel");

  chk_reload_off: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (!reload_en && !(|cmp_wr_lo) && !(|cmp_wr_hi))
    |=> $stable(compare_value))
    else $error("compare changed with reload disabled");

  // Period length and per-channel wrap
  chk_wrap_short: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (!chan_pwm16[1] && cycle_overflow_flag_event) |=> cycle_wrap[1])
    else $error("short cycle wrap missing");

  chk_mask_range: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !sys_rst |=> (&cycle_mask[BYTE_W-1:0]) && !cycle_mask[CNT_W-1])
    else $error("cycle length outside 8 to 15 bits");

  chk_wrap_full: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (chan_pwm16[2] && !full_overflow) |=> !cycle_wrap[2])
    else $error("16-bit channel wrapped before full count");

  chk_wide_ignores_len: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (chan_pwm16[0] && cycle_overflow_flag_event && !full_overflow)
    |=> !cycle_wrap[0])
    else $error("16-bit channel followed the length field");

  chk_length_code: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !sys_rst |=> cycle_mask == 16'((32'h1 << (32'($past(cycle_length_select)) +
                 32'(BASE_CYCLE_BITS))) - 32'h1))
    else $error("cycle length does not match code plus eight");

  // Interrupt line and bank steering
  chk_irq_raise: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (irq_en && cycle_overflow_flag_event && !ctrl_wr) |=> irq ##1
    (irq || $past(ctrl_wr)))
    else $error("interrupt not raised for enabled overflow");

  chk_irq_masked: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (!irq_en && !(|(status_reg & mask_reg))) |-> !irq)
    else $error("interrupt raised while disabled");

  chk_bank_read: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (reg_read && reg_addr == ADDR_CMP_BASE && bank_sel)
    |=> reg_rdata == $past(reload_value[0][BYTE_W-1:0]))
    else $error("shadow bank read returned wrong byte");

  chk_cmp_read: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (reg_read && reg_addr == ADDR_CMP_BASE && !bank_sel)
    |=> reg_rdata == $past(compare_value[0][BYTE_W-1:0]))
    else $error("compare bank read returned wrong byte");

  chk_shadow_write: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (cmp_wr_lo[0] && bank_sel && !chan_reload[0])
    |=> $stable(compare_value[0]))
    else $error("shadow bank write reached the compare register");

  // Main scenarios
  cov_reload: cover property (@(posedge sys_clk) disable iff (sys_rst)
    chan_reload[0] ##1 cycle_wrap[0]);
  cov_short_irq: cover property (@(posedge sys_clk) disable iff (sys_rst)
    (cycle_length_select == 3'h7) && cycle_overflow_flag_event ##1 irq);
  cov_set_clear: cover property (@(posedge sys_clk) disable iff (sys_rst)
    cycle_overflow_flag_event && ctrl_wr && !reg_wdata[BIT_CYCLE_OVERFLOW_FLAG]);
  cov_shadow_write: cover property (@(posedge sys_clk) disable iff (sys_rst)
    bank_sel && (|cmp_wr_hi));
  cov_wide_skip: cover property (@(posedge sys_clk) disable iff (sys_rst)
    chan_pwm16[0] && cycle_overflow_flag_event && !full_overflow);

endmodule

// ### verification/pwm_cycle_length_reload_ctrl_bench.sv
`timescale 1ns/1ps

module pwm_cycle_length_reload_ctrl_bench;
  import pwm_ctrl_pkg::*;

  logic                           sys_clk      = 1'b0;
  logic                           sys_rst      = 1'b1;
  logic [7:0]                     reg_addr     = 8'h00;
  logic [BYTE_W-1:0]              reg_wdata    = 8'h00;
  logic                           reg_write    = 1'b0;
  logic                           reg_read     = 1'b0;
  logic [BYTE_W-1:0]              reg_rdata;
  logic [CNT_W-1:0]               main_counter = 16'h0000;
  logic                           counter_step = 1'b0;
  logic [CHANNELS-1:0]            chan_pwm16   = 3'h0;
  logic [CHANNELS-1:0][CNT_W-1:0] compare_value;
  logic [CHANNELS-1:0]            cycle_wrap;
  logic [CNT_W-1:0]               cycle_mask;
  logic                           irq;
  int                             fail_count   = 0;
  int                             compares     = 0;
  int                             cycles       = 0;
  logic [31:0]                    seed         = 32'h00000028;
  logic [31:0]                    r;
  logic [15:0]                    m;
  logic [2:0]                     cur_code     = 3'h0;
  logic [15:0]                    cmp_exp [CHANNELS];
  logic [15:0]                    shd_exp [CHANNELS];

  pwm_cycle_length_reload_ctrl dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .main_counter(main_counter),
    .counter_step(counter_step), .chan_pwm16(chan_pwm16),
    .compare_value(compare_value), .cycle_wrap(cycle_wrap),
    .cycle_mask(cycle_mask), .irq(irq)
  );

  // Free-running 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  // Xorshift keeps the run repeatable from one seed
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Low N bits set, N being 8 plus the code
  function logic [15:0] len_mask(input logic [2:0] code);
    return 16'hffff >> (4'h8 - {1'b0, code});
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Strobe is lowered one edge early so a following call never
  // assigns it twice in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 check({8'h00, reg_rdata}, {8'h00, exp});
    @(posedge sys_clk);
  endtask

  task automatic wr_slot(input int c, input logic [15:0] v);
    logic [7:0] a;
    a = ADDR_CMP_BASE + 8'(2 * c);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask

  task automatic rd_slot(input int c, input logic [15:0] v);
    logic [7:0] a;
    a = ADDR_CMP_BASE + 8'(2 * c);
    rdchk(a, v[7:0]);
    rdchk(a + 8'h01, v[15:8]);
  endtask

  // One counter step; wrap expectation worked out per channel mode
  task automatic step(input logic [15:0] cnt);
    logic [CHANNELS-1:0] w;
    m = len_mask(cur_code);
    for (int c = 0; c < CHANNELS; c++)
      w[c] = chan_pwm16[c] ? (cnt == FULL_COUNT) : ((cnt & m) == m);
    main_counter <= cnt;
    counter_step <= 1'b1;
    @(posedge sys_clk);
    counter_step <= 1'b0;
    #1 check({13'h0000, cycle_wrap}, {13'h0000, w});
    check(cycle_mask, m);
    @(posedge sys_clk);
    #1 check({13'h0000, cycle_wrap}, 16'h0000);
    @(posedge sys_clk);
  endtask

  // Hang guard; the whole sequence needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rdchk(ADDR_CONTROL, CTRL_RESET);
    rdchk(ADDR_EVT_STATUS, 8'h00);
    // Every length code: near miss, hit, then a miss that must not clear
    for (int k = 0; k < 8; k++) begin
      cur_code = k[2:0];
      m = len_mask(cur_code);
      r = rnd();
      chan_pwm16 <= r[2:0];
      wr(ADDR_CONTROL, {5'h00, cur_code});
      wr(ADDR_EVT_STATUS, 8'h03);
      r = rnd();
      step((r[15:0] & ~m) | (m >> 1));
      rdchk(ADDR_CONTROL, {5'h00, cur_code});
      step((r[15:0] & ~m) | m);
      rdchk(ADDR_CONTROL, {5'h04, cur_code});
      step((r[15:0] & ~m) | (m >> 1));
      rdchk(ADDR_CONTROL, {5'h04, cur_code});
      rdchk(ADDR_EVT_STATUS, 8'h01);
    end
    cur_code = 3'h0;
    // Software set and clear; bit 4 never sticks
    wr(ADDR_CONTROL, 8'h30);
    rdchk(ADDR_CONTROL, 8'h20);
    wr(ADDR_CONTROL, 8'h00);
    rdchk(ADDR_CONTROL, 8'h00);
    // Interrupt through the enable, then through status and mask
    wr(ADDR_CONTROL, 8'h60);
    check({15'h0000, irq}, 16'h0001);
    wr(ADDR_CONTROL, 8'h40);
    check({15'h0000, irq}, 16'h0000);
    // Enabled overflow raises the line; a clear in the same cycle loses
    step(16'h00ff);
    check({15'h0000, irq}, 16'h0001);
    main_counter <= 16'h00ff;
    counter_step <= 1'b1;
    reg_addr     <= ADDR_CONTROL;
    reg_wdata    <= 8'h40;
    reg_write    <= 1'b1;
    @(posedge sys_clk);
    counter_step <= 1'b0;
    reg_write    <= 1'b0;
    @(posedge sys_clk);
    rdchk(ADDR_CONTROL, 8'h60);
    wr(ADDR_CONTROL, 8'h40);
    wr(ADDR_EVT_MASK, 8'h01);
    rdchk(ADDR_EVT_MASK, 8'h01);
    check({15'h0000, irq}, 16'h0001);
    wr(ADDR_EVT_STATUS, 8'h01);
    rdchk(ADDR_EVT_STATUS, 8'h00);
    check({15'h0000, irq}, 16'h0000);
    wr(ADDR_EVT_MASK, 8'h00);
    // Unmapped place ignores writes and reads zero
    wr(8'h20, 8'hff);
    rdchk(8'h20, 8'h00);
    // Compare and shadow banks, then reload off and on
    chan_pwm16 <= 3'b101;
    wr(ADDR_CONTROL, 8'h00);
    for (int c = 0; c < CHANNELS; c++) begin
      r = rnd();
      cmp_exp[c] = r[15:0];
      shd_exp[c] = r[31:16];
      wr_slot(c, cmp_exp[c]);
    end
    wr(ADDR_CONTROL, 8'h80);
    for (int c = 0; c < CHANNELS; c++)
      wr_slot(c, shd_exp[c]);
    for (int c = 0; c < CHANNELS; c++) begin
      rd_slot(c, shd_exp[c]);
      check(compare_value[c], cmp_exp[c]);
    end
    step(16'hffff);
    for (int c = 0; c < CHANNELS; c++)
      check(compare_value[c], cmp_exp[c]);
    wr(ADDR_CONTROL, 8'h88);
    wr(ADDR_EVT_STATUS, 8'h03);
    step(16'hfffe);
    for (int c = 0; c < CHANNELS; c++)
      check(compare_value[c], cmp_exp[c]);
    step(16'hffff);
    for (int c = 0; c < CHANNELS; c++) begin
      if (chan_pwm16[c])
        cmp_exp[c] = shd_exp[c];
      check(compare_value[c], cmp_exp[c]);
    end
    rdchk(ADDR_EVT_STATUS, 8'h03);
    wr(ADDR_CONTROL, 8'h08);
    for (int c = 0; c < CHANNELS; c++)
      rd_slot(c, cmp_exp[c]);
    print_verdict();
  end

endmodule
